// *** core/bitop_pkg.sv ***
// Package for the bit-oriented file-register execution block.
// Assumes a 14-bit instruction word and an 8-bit data memory path.
package bitop_pkg;
  localparam int INSTR_W = 14;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int DATA_W = 8;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 10;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int ADDR_HI = 6;
  localparam int ADDR_LO = 0;
  localparam logic [3:0] CLEAR_FILE_BIT_OP = 4'h4;
  localparam logic [3:0] SET_FILE_BIT_OP = 4'h5;
  localparam logic [3:0] TEST_BIT_SKIP_IF_ZERO_OP = 4'h6;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_CLEAR = 2'b01,
    OP_SET = 2'b10,
    OP_TEST = 2'b11
  } bitop_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic rd;
    logic wr;
  } mem_req_s;

  typedef struct packed {
    phase_e phase;
    bitop_e op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0] bit_idx;
    logic [DATA_W-1:0] data;
    logic skip_next;
    logic squash;
    mem_req_s mem;
    logic skip_pulse;
  } state_s;
endpackage

// *** core/bit_file_ops.sv ***
// Executes clear-bit, set-bit and test-bit-skip-if-zero instructions.
// Holds the per-bit modify lane and the field decoder beside the top module.
// Assumes clk_in advances one quadrature phase per rising edge, Q1 first after reset;
// instr_in is the latched instruction valid for a whole instruction cycle;
// rd_data_in returns the addressed file register in the same cycle as rd.
`default_nettype none

// One bit of the modify path, chosen by its lane number;
// lanes that are not chosen pass the read bit through.
module bit_lane #(
  parameter int LANE = 0
) (
  input wire logic [bitop_pkg::BIT_W-1:0] bit_idx_in,
  input wire logic [1:0] op_in,
  input wire logic rd_bit_in,
  output logic new_bit_out,
  output logic zero_out
);
  logic sel;
  logic [bitop_pkg::BIT_W-1:0] lane_idx;

  assign lane_idx = bitop_pkg::BIT_W'(LANE);

  always_comb begin
    sel = (bit_idx_in == lane_idx);
    new_bit_out = rd_bit_in;
    zero_out = 1'b0;
    if (sel) begin
      case (op_in)
        bitop_pkg::OP_CLEAR: begin
          new_bit_out = 1'b0;
        end
        bitop_pkg::OP_SET: begin
          new_bit_out = 1'b1;
        end
        bitop_pkg::OP_TEST: begin
          zero_out = ~rd_bit_in;
        end
        default: begin
          new_bit_out = rd_bit_in;
        end
      endcase
    end else begin
      new_bit_out = rd_bit_in;
      zero_out = 1'b0;
    end
  end
endmodule

// Field decode of the held instruction word;
// a discarded slot decodes to no operation.
module op_decode (
  input wire logic [bitop_pkg::INSTR_W-1:0] instr_in,
  input wire logic squash_in,
  output bitop_pkg::bitop_e op_out,
  output logic [bitop_pkg::ADDR_W-1:0] addr_out,
  output logic [bitop_pkg::BIT_W-1:0] bit_idx_out
);
  logic [bitop_pkg::OPC_HI-bitop_pkg::OPC_LO:0] opc;

  always_comb begin
    opc = instr_in[bitop_pkg::OPC_HI:bitop_pkg::OPC_LO];
    addr_out = instr_in[bitop_pkg::ADDR_HI:bitop_pkg::ADDR_LO];
    bit_idx_out = instr_in[bitop_pkg::BIT_HI:bitop_pkg::BIT_LO];
    case (opc)
      bitop_pkg::CLEAR_FILE_BIT_OP: begin
        op_out = bitop_pkg::OP_CLEAR;
      end
      bitop_pkg::SET_FILE_BIT_OP: begin
        op_out = bitop_pkg::OP_SET;
      end
      bitop_pkg::TEST_BIT_SKIP_IF_ZERO_OP: begin
        op_out = bitop_pkg::OP_TEST;
      end
      default: begin
        op_out = bitop_pkg::OP_NONE;
      end
    endcase

    if (squash_in) begin
      op_out = bitop_pkg::OP_NONE;
    end
  end
endmodule

// Four-phase sequencer and read-modify-write control
module bit_file_ops (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [bitop_pkg::INSTR_W-1:0] instr_in,
  input wire logic [bitop_pkg::DATA_W-1:0] rd_data_in,
  output logic [1:0] phase_out,
  output bitop_pkg::mem_req_s mem_out,
  output logic squash_out,
  output logic skip_out,
  output logic status_we_out
);
  bitop_pkg::state_s s_q;
  bitop_pkg::state_s s_d;
  bitop_pkg::bitop_e op_dec;
  logic [bitop_pkg::ADDR_W-1:0] addr_dec;
  logic [bitop_pkg::BIT_W-1:0] bit_dec;
  logic [bitop_pkg::DATA_W-1:0] lane_bits;
  logic [bitop_pkg::DATA_W-1:0] lane_zero;

  // Decode of the word held this cycle
  op_decode decode_u (
    .instr_in(instr_in),
    .squash_in(s_q.skip_next),
    .op_out(op_dec),
    .addr_out(addr_dec),
    .bit_idx_out(bit_dec)
  );

  // One modify lane per data bit
  for (genvar lane = 0; lane < bitop_pkg::DATA_W; lane++) begin : g_lane
    bit_lane #(
      .LANE(lane)
    ) lane_u (
      .bit_idx_in(s_q.bit_idx),
      .op_in(s_q.op),
      .rd_bit_in(rd_data_in[lane]),
      .new_bit_out(lane_bits[lane]),
      .zero_out(lane_zero[lane])
    );
  end

  // Phase sequencer
  always_comb begin
    s_d = s_q;
    s_d.mem.rd = 1'b0;
    s_d.mem.wr = 1'b0;
    s_d.skip_pulse = 1'b0;
    case (s_q.phase)
      bitop_pkg::PH_Q1: begin
        s_d.phase = bitop_pkg::PH_Q2;
        s_d.squash = s_q.skip_next;
        s_d.skip_next = 1'b0;
        s_d.addr = addr_dec;
        s_d.bit_idx = bit_dec;
        s_d.op = op_dec;
      end

      bitop_pkg::PH_Q2: begin
        s_d.phase = bitop_pkg::PH_Q3;
        if (s_q.op != bitop_pkg::OP_NONE) begin
          s_d.mem.rd = 1'b1;
          s_d.mem.addr = s_q.addr;
        end
      end

      bitop_pkg::PH_Q3: begin
        s_d.phase = bitop_pkg::PH_Q4;
        case (s_q.op)
          bitop_pkg::OP_CLEAR: begin
            s_d.data = lane_bits;
          end
          bitop_pkg::OP_SET: begin
            s_d.data = lane_bits;
          end
          bitop_pkg::OP_TEST: begin
            s_d.data = rd_data_in;
            s_d.skip_next = |lane_zero;
          end
          default: begin
            s_d.data = s_q.data;
          end
        endcase
      end

      bitop_pkg::PH_Q4: begin
        s_d.phase = bitop_pkg::PH_Q1;
        if (s_q.op == bitop_pkg::OP_CLEAR || s_q.op == bitop_pkg::OP_SET) begin
          s_d.mem.wr = 1'b1;
          s_d.mem.addr = s_q.addr;
          s_d.mem.data = s_q.data;
        end
        s_d.skip_pulse = s_q.skip_next;
      end
      default: begin
        s_d.phase = bitop_pkg::PH_Q1;
        s_d.op = bitop_pkg::OP_NONE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops, except status_we_out tied low
  assign phase_out = s_q.phase;
  assign mem_out = s_q.mem;
  assign squash_out = s_q.squash;
  assign skip_out = s_q.skip_pulse;
  assign status_we_out = 1'b0;
endmodule
`default_nettype wire

// *** testbench/bit_file_ops_properties.sv ***
// Port timing checker for bit_file_ops.
// Assumes binding to the design.
`default_nettype none
module bit_file_ops_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] rd_data_in,
  input wire logic [1:0] phase_out,
  input wire bitop_pkg::mem_req_s mem_out,
  input wire logic squash_out,
  input wire logic skip_out,
  input wire logic status_we_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_sq; squash_out [*3]; endsequence
  property p_rd; mem_out.rd |-> phase_out == 2'h2 && mem_out.addr == instr_in[6:0]; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_wr; mem_out.wr |-> phase_out == 2'h0 && $past(mem_out.rd, 2); endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_data; mem_out.wr |-> mem_out.data[$past(instr_in[9:7])] == $past(instr_in[10]);
  endproperty
  a_data: assert property (p_data) else $error("bad bit");
  property p_keep; mem_out.wr |-> ((mem_out.data ^ $past(rd_data_in, 2)) &
    ~(8'h01 << $past(instr_in[9:7]))) == 8'h00; endproperty
  a_keep: assert property (p_keep) else $error("other bits changed");
  property p_skip; phase_out == 2'h0 && $past(phase_out) == 2'h3 && $past(instr_in[13:10]) ==
    4'h6 |-> skip_out == (!squash_out && !$past(rd_data_in[instr_in[9:7]], 2)); endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  property p_sq; skip_out |-> $past(instr_in[13:10]) == 4'h6 ##1 s_sq; endproperty
  a_sq: assert property (p_sq) else $error("bad squash");
  property p_fl; !status_we_out; endproperty
  a_fl: assert property (p_fl) else $error("flag write");
endmodule
bind bit_file_ops bit_file_ops_chk chk_u (.clk_in, .reset_in, .instr_in, .rd_data_in,
  .phase_out, .mem_out, .squash_out, .skip_out, .status_we_out);
`default_nettype wire

// *** testbench/file_mem_model.sv ***
// Data memory model for file register reads and writes.
// Assumes reads are answered within the read cycle.
`default_nettype none
module file_mem_model (
  input wire logic clk_in,
  input wire bitop_pkg::mem_req_s mem_in,
  output logic [7:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [128];
  assign rd_data_out = mem_in.rd ? m[mem_in.addr] : ~m[mem_in.addr];
  always @(posedge clk_in) if (mem_in.wr) m[mem_in.addr] <= mem_in.data;
endmodule
`default_nettype wire

// *** testbench/bit_file_ops_test.sv ***
// Bench for bit_file_ops with a memory model.
// Assumes the checker binds itself.
`default_nettype none
module bit_file_ops_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0, reset_in = 1'h1, sq, sk, we, s, k;
  logic [13:0] instr_in = 14'h0;
  logic [7:0] rd;
  logic [1:0] ph;
  bitop_pkg::mem_req_s mem;
  int mismatches = 0, n_compared = 0;
  bit_file_ops dut_u (.clk_in, .reset_in, .instr_in, .rd_data_in(rd), .phase_out(ph),
    .mem_out(mem), .squash_out(sq), .skip_out(sk), .status_we_out(we));
  file_mem_model m_u (.clk_in, .mem_in(mem), .rd_data_out(rd));
  initial forever #25 clk_in = ~clk_in;
  task chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task issue(input logic [13:0] i);
    do @(negedge clk_in); while (ph !== 2'h3);
    @(posedge clk_in) instr_in <= i;
  endtask
  task run(input logic [13:0] a, b);
    issue(a);
    issue(b);
    @(negedge clk_in);
    k = sk;
    repeat (2) @(negedge clk_in);
    s = sq;
    issue(14'h0);
    issue(14'h0);
  endtask
  task print_verdict;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_set;
    run(14'h17ff, 14'h0);
    chk(m_u.m[127], 8'h8a);
    chk({7'h0, we}, 8'h00);
  endtask
  task t_clr;
    run(14'h1380, 14'h0);
    chk(m_u.m[0], 8'h47);
  endtask
  task t_skip;
    run(14'h1801, 14'h1402);
    chk(m_u.m[2], 8'h00);
    chk({7'h0, s}, 8'h01);
    chk({7'h0, k}, 8'h01);
  endtask
  task t_noskip;
    run(14'h1881, 14'h1402);
    chk(m_u.m[2], 8'h01);
    chk({7'h0, s}, 8'h00);
    chk({7'h0, k}, 8'h00);
  endtask
  initial begin
    m_u.m[127] = 8'h0a;
    m_u.m[0] = 8'hc7;
    m_u.m[1] = 8'hfe;
    m_u.m[2] = 8'h00;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'h0;
    t_set;
    t_clr;
    t_skip;
    t_noskip;
    print_verdict;
  end
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
endmodule
`default_nettype wire
